// File: hdl/wpt_i2c_slave.sv
// two-wire slave for a 7-bit volatile wiper, with supply-level gating.
// assumes pins arrive unfiltered from pads and the pad logic resolves
// open-drain levels from the *_oe outputs.
//
// Overview of operation
// - supply good loads wiper with mid-scale
// - supply below trip disables interface entirely
// - stop enters static mode, start leaves it
// - seven-bit slave only, never drives clock
// - oversampling covers 100 and 400 kb/s
// - lines only pulled low or released
// - sda falling while scl high is start
// - sda changes only while scl low
// - matching address acknowledged on ninth clock, a read only after a command byte and a repeated start
// - address mismatch answered with released sda
// - start while bus still active (no stop, collision or supply loss since) is repeated start
// - collision during transmit resets interface logic
// - sda rising while scl high is stop
// - any stop returns machine to idle
// - clock is never stretched
// - malformed or cut transfers leave wiper untouched
// - only the serial link writes wiper
// - non-zero command code blocks wiper writes
// - data msb ignored, low seven stored
// - writes commit only in acknowledge bit
// - undefined command and its data byte still acknowledged, data not stored
`timescale 1ns/1ps
module wpt_i2c_slave (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic supply_ok,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic scl_oe,
   output logic sda_out,
   output logic sda_oe,
   output logic [6:0] wiper_value,
   output logic bus_active,
   output logic bus_collision
);

   // ----------------------------------------------------------------
   // input synchronisation and edge events
   // ----------------------------------------------------------------
   logic [2:0] sync_q;
   logic pwr_ok;
   wpt_pkg::wpt_pins_t pins_s;
   wpt_pkg::wpt_pins_t pins_d_reg;
   logic scl_rise;
   logic scl_fall;
   logic start_evt;
   logic stop_evt;

   wpt_sync #(
      .W(3),
      .RST_VAL(wpt_pkg::WPT_SYNC_RESET)
   ) u_sync (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .clk_en(clk_en),
      .d({supply_ok, scl_in, sda_in}),
      .q(sync_q)
   );

   assign pwr_ok = sync_q[2];
   assign pins_s = wpt_pkg::wpt_pins_t'(sync_q[1:0]);

   // idle bus reads high, so no false edge at reset release
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pins_d_reg <= wpt_pkg::wpt_pins_t'(2'h3);
      end else if (clk_en) begin
         pins_d_reg <= pins_s;
      end
   end

   assign scl_rise = pins_s.scl && !pins_d_reg.scl;
   assign scl_fall = !pins_s.scl && pins_d_reg.scl;
   assign start_evt = pins_s.scl && pins_d_reg.scl && pins_d_reg.sda && !pins_s.sda;
   assign stop_evt = pins_s.scl && pins_d_reg.scl && !pins_d_reg.sda && pins_s.sda;

   // ----------------------------------------------------------------
   // protocol state
   // ----------------------------------------------------------------
   wpt_pkg::wpt_state_t state_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic [7:0] tx_reg;
   logic sda_oe_reg;
   logic active_reg;
   logic repeat_reg;
   logic cmd_seen_reg;
   logic cmd_ok_reg;
   logic read_reg;
   logic master_nak_reg;
   logic collision_reg;
   logic wr_en_reg;
   logic [6:0] wr_data_reg;
   logic [6:0] wiper_q;
   logic byte_done;
   logic addr_hit;

   assign byte_done = bit_cnt_reg == wpt_pkg::WPT_BITS_PER_BYTE;
   // general call and foreign addresses both miss
   assign addr_hit = shift_reg[7:1] == wpt_pkg::WPT_SLAVE_ADDR;

   // start and stop are checked before any clock edge, so a cut
   // transfer never reaches its acknowledge slot and never writes
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= wpt_pkg::WPT_IDLE;
         bit_cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         tx_reg <= 8'h00;
         sda_oe_reg <= 1'h0;
         active_reg <= 1'h0;
         repeat_reg <= 1'h0;
         cmd_seen_reg <= 1'h0;
         cmd_ok_reg <= 1'h0;
         read_reg <= 1'h0;
         master_nak_reg <= 1'h0;
         collision_reg <= 1'h0;
      end else if (clk_en) begin
         collision_reg <= 1'h0;
         if (!pwr_ok) begin
            state_reg <= wpt_pkg::WPT_IDLE;
            sda_oe_reg <= 1'h0;
            active_reg <= 1'h0;
            cmd_seen_reg <= 1'h0;
         end else if (stop_evt) begin
            state_reg <= wpt_pkg::WPT_IDLE;
            sda_oe_reg <= 1'h0;
            active_reg <= 1'h0;
            cmd_seen_reg <= 1'h0;
         end else if (start_evt) begin
            state_reg <= wpt_pkg::WPT_ADDR;
            bit_cnt_reg <= 4'h0;
            sda_oe_reg <= 1'h0;
            active_reg <= 1'h1;
            repeat_reg <= active_reg;
            if (!active_reg) begin
               cmd_seen_reg <= 1'h0;
            end
         end else if (scl_rise) begin
            unique case (state_reg)
               wpt_pkg::WPT_ADDR, wpt_pkg::WPT_CMD, wpt_pkg::WPT_DATA: begin
                  shift_reg <= {shift_reg[6:0], pins_s.sda};
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end
               wpt_pkg::WPT_TX: begin
                  // released for a one yet the line reads low
                  if (!sda_oe_reg && !pins_s.sda) begin
                     state_reg <= wpt_pkg::WPT_IDLE;
                     collision_reg <= 1'h1;
                     active_reg <= 1'h0;
                     cmd_seen_reg <= 1'h0;
                  end else begin
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end
               end
               wpt_pkg::WPT_TX_ACK: begin
                  master_nak_reg <= pins_s.sda;
               end
               wpt_pkg::WPT_IDLE, wpt_pkg::WPT_ADDR_ACK, wpt_pkg::WPT_CMD_ACK,
               wpt_pkg::WPT_DATA_ACK, wpt_pkg::WPT_IGNORE: begin
               end
            endcase
         end else if (scl_fall) begin
            // every sda pull-low begins here, with scl low
            unique case (state_reg)
               wpt_pkg::WPT_ADDR: begin
                  if (byte_done) begin
                     bit_cnt_reg <= 4'h0;
                     if (!addr_hit) begin
                        state_reg <= wpt_pkg::WPT_IGNORE;
                     end else if (!shift_reg[0]) begin
                        state_reg <= wpt_pkg::WPT_ADDR_ACK;
                        sda_oe_reg <= 1'h1;
                        read_reg <= 1'h0;
                     end else if (cmd_seen_reg && repeat_reg) begin
                        state_reg <= wpt_pkg::WPT_ADDR_ACK;
                        sda_oe_reg <= 1'h1;
                        read_reg <= 1'h1;
                        tx_reg <= {1'h0, wiper_q};
                     end else begin
                        state_reg <= wpt_pkg::WPT_IGNORE;
                     end
                  end
               end
               wpt_pkg::WPT_ADDR_ACK: begin
                  if (read_reg) begin
                     state_reg <= wpt_pkg::WPT_TX;
                     sda_oe_reg <= !tx_reg[7];
                     tx_reg <= {tx_reg[6:0], 1'h0};
                  end else begin
                     state_reg <= wpt_pkg::WPT_CMD;
                     sda_oe_reg <= 1'h0;
                  end
               end
               wpt_pkg::WPT_CMD: begin
                  if (byte_done) begin
                     bit_cnt_reg <= 4'h0;
                     cmd_ok_reg <= shift_reg == wpt_pkg::WPT_CMD_WIPER;
                     cmd_seen_reg <= 1'h1;
                     sda_oe_reg <= 1'h1;
                     state_reg <= wpt_pkg::WPT_CMD_ACK;
                  end
               end
               wpt_pkg::WPT_CMD_ACK, wpt_pkg::WPT_DATA_ACK: begin
                  sda_oe_reg <= 1'h0;
                  state_reg <= wpt_pkg::WPT_DATA;
               end
               wpt_pkg::WPT_DATA: begin
                  if (byte_done) begin
                     bit_cnt_reg <= 4'h0;
                     sda_oe_reg <= 1'h1;
                     state_reg <= wpt_pkg::WPT_DATA_ACK;
                  end
               end
               wpt_pkg::WPT_TX: begin
                  if (byte_done) begin
                     bit_cnt_reg <= 4'h0;
                     sda_oe_reg <= 1'h0;
                     state_reg <= wpt_pkg::WPT_TX_ACK;
                  end else begin
                     sda_oe_reg <= !tx_reg[7];
                     tx_reg <= {tx_reg[6:0], 1'h0};
                  end
               end
               wpt_pkg::WPT_TX_ACK: begin
                  if (master_nak_reg) begin
                     state_reg <= wpt_pkg::WPT_IGNORE;
                  end else begin
                     // msb of the wiper byte is always zero
                     state_reg <= wpt_pkg::WPT_TX;
                     sda_oe_reg <= 1'h1;
                     tx_reg <= {wiper_q, 1'h0};
                  end
               end
               wpt_pkg::WPT_IDLE, wpt_pkg::WPT_IGNORE: begin
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // wiper write path
   // ----------------------------------------------------------------
   // commit on the rising clock of the acknowledge bit only
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         wr_en_reg <= 1'h0;
         wr_data_reg <= 7'h00;
      end else if (clk_en) begin
         wr_en_reg <= 1'h0;
         if (pwr_ok && !stop_evt && !start_evt && scl_rise && state_reg == wpt_pkg::WPT_DATA_ACK
             && cmd_ok_reg) begin
            wr_en_reg <= 1'h1;
            wr_data_reg <= shift_reg[6:0];
         end
      end
   end

   wpt_wiper_reg u_wiper (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .clk_en(clk_en),
      .pwr_ok(pwr_ok),
      .wr_en(wr_en_reg),
      .wr_data(wr_data_reg),
      .wiper(wiper_q)
   );

   // ----------------------------------------------------------------
   // pin and status outputs
   // ----------------------------------------------------------------
   // the clock pin is kept as a registered, never-enabled driver
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         scl_out <= 1'h0;
         scl_oe <= 1'h0;
         sda_out <= 1'h0;
      end else if (clk_en) begin
         scl_out <= 1'h0;
         scl_oe <= 1'h0;
         sda_out <= 1'h0;
      end
   end

   assign sda_oe = sda_oe_reg;
   assign wiper_value = wiper_q;
   assign bus_active = active_reg;
   assign bus_collision = collision_reg;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   sequence s_addr_byte_end;
      clk_en && pwr_ok && !start_evt && !stop_evt && scl_fall && state_reg == wpt_pkg::WPT_ADDR && byte_done;
   endsequence

   sequence s_tx_clash;
      clk_en && pwr_ok && !start_evt && !stop_evt && scl_rise && state_reg == wpt_pkg::WPT_TX
         && !sda_oe_reg && !pins_s.sda;
   endsequence

   chk_clock_not_held: assert property (!scl_oe)
      else $error("clock line driven");
   chk_below_trip_quiet: assert property (clk_en && !pwr_ok |=> !sda_oe && state_reg == wpt_pkg::WPT_IDLE)
      else $error("interface active below trip");
   chk_stop_to_idle: assert property (clk_en && pwr_ok && stop_evt |=> state_reg == wpt_pkg::WPT_IDLE && !bus_active)
      else $error("stop did not idle");
   chk_start_to_addr: assert property (clk_en && pwr_ok && !stop_evt && start_evt |=> state_reg == wpt_pkg::WPT_ADDR)
      else $error("start not taken");
   chk_match_acked: assert property (s_addr_byte_end ##0 (addr_hit && !shift_reg[0]) |=> sda_oe ##0 state_reg == wpt_pkg::WPT_ADDR_ACK)
      else $error("address not acknowledged");
   chk_miss_nacked: assert property (s_addr_byte_end ##0 !addr_hit |=> !sda_oe && state_reg == wpt_pkg::WPT_IGNORE)
      else $error("foreign address acknowledged");
   chk_drive_scl_low: assert property ($rose(sda_oe_reg) |-> $past(scl_fall) && !pins_s.scl)
      else $error("sda pulled while scl high");
   chk_collision_reset: assert property (s_tx_clash |=> bus_collision && state_reg == wpt_pkg::WPT_IDLE)
      else $error("collision not handled");
   chk_commit_in_ack: assert property (wr_en_reg |-> $past(state_reg) == wpt_pkg::WPT_DATA_ACK && $past(cmd_ok_reg))
      else $error("write outside acknowledge");
   chk_read_needs_restart: assert property (s_addr_byte_end ##0 (addr_hit && shift_reg[0] && !repeat_reg) |=> !sda_oe)
      else $error("read without restart accepted");

endmodule

// File: hdl/wpt_pkg.sv
// wiper pot serial slave: shared constants, pin carrier and state type.
// assumes one 125 MHz system clock; no software-visible registers.
package wpt_pkg;

   // ----------------------------------------------------------------
   // protocol constants
   // ----------------------------------------------------------------
   localparam logic [6:0] WPT_SLAVE_ADDR = 7'h2E;
   localparam logic [6:0] WPT_WIPER_DEFAULT = 7'h3F;
   localparam logic [7:0] WPT_CMD_WIPER = 8'h00;
   localparam logic [3:0] WPT_BITS_PER_BYTE = 4'h8;
   localparam logic [2:0] WPT_SYNC_RESET = 3'h3;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic scl;
      logic sda;
   } wpt_pins_t;

   typedef enum logic [3:0] {
      WPT_IDLE,
      WPT_ADDR,
      WPT_ADDR_ACK,
      WPT_CMD,
      WPT_CMD_ACK,
      WPT_DATA,
      WPT_DATA_ACK,
      WPT_TX,
      WPT_TX_ACK,
      WPT_IGNORE
   } wpt_state_t;

endpackage

// File: hdl/wpt_sync.sv
// two-stage synchroniser for a group of asynchronous inputs.
// assumes inputs may change at any time relative to sys_clk.
`timescale 1ns/1ps
module wpt_sync #(
   parameter int W = 3,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   // ----------------------------------------------------------------
   // metastability stages
   // ----------------------------------------------------------------
   logic [W-1:0] meta_reg;

   // the first stage feeds only the second stage
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         meta_reg <= RST_VAL;
         q <= RST_VAL;
      end else if (clk_en) begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end

endmodule

// File: hdl/wpt_wiper_reg.sv
// volatile 7-bit wiper register with supply-good default load.
// assumes pwr_ok is already synchronised and writes arrive as pulses.
`timescale 1ns/1ps
module wpt_wiper_reg (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic pwr_ok,
   input wire logic wr_en,
   input wire logic [6:0] wr_data,
   output logic [6:0] wiper
);

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   logic pwr_ok_d_reg;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pwr_ok_d_reg <= 1'h0;
      end else if (clk_en) begin
         pwr_ok_d_reg <= pwr_ok;
      end
   end

   // supply recovery wins over any write in the same cycle
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         wiper <= wpt_pkg::WPT_WIPER_DEFAULT;
      end else if (clk_en) begin
         if (pwr_ok && !pwr_ok_d_reg) begin
            wiper <= wpt_pkg::WPT_WIPER_DEFAULT;
         end else if (wr_en && pwr_ok) begin
            wiper <= wr_data;
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   chk_default_on_power: assert property (clk_en && pwr_ok && !pwr_ok_d_reg |=> wiper == wpt_pkg::WPT_WIPER_DEFAULT)
      else $error("wiper not at default after supply good");
   chk_write_lands: assert property (clk_en && wr_en && pwr_ok && pwr_ok_d_reg |=> wiper == $past(wr_data))
      else $error("wiper write lost");

endmodule

// File: testbench/wpt_i2c_master_model.sv
// bus master model for the wiper slave: drives scl and sda open drain.
// assumes pull-ups on both lines and a bench that calls its tasks in turn.
`timescale 1ns/1ps
module wpt_i2c_master_model #(
   parameter int HALF = 20,
   parameter int QTR = 5
) (
   input wire logic sys_clk,
   input wire logic scl_oe_dev,
   input wire logic sda_oe_dev,
   output logic scl,
   output logic sda
);
   logic scl_low = 1'b0;
   logic sda_low = 1'b0;

   // ----------------------------------------------------------------
   // wired-and bus with pull-ups
   // ----------------------------------------------------------------
   // a released line reads high, never the last driven value
   assign scl = ~(scl_low | scl_oe_dev);
   assign sda = ~(sda_low | sda_oe_dev);

   // ----------------------------------------------------------------
   // bus conditions and bits
   // ----------------------------------------------------------------
   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // needs both lines released, so after a refused byte a stop comes first; a start after a stop resets the slave
   task automatic start();
      sda_low <= 1'b1;
      wt(HALF);
      scl_low <= 1'b1;
   endtask

   task automatic restart();
      wt(QTR);
      sda_low <= 1'b0;
      wt(HALF);
      scl_low <= 1'b0;
      wt(HALF);
      sda_low <= 1'b1;
      wt(HALF);
      scl_low <= 1'b1;
   endtask

   task automatic stop();
      wt(QTR);
      sda_low <= 1'b1;
      wt(HALF);
      scl_low <= 1'b0;
      wt(HALF);
      sda_low <= 1'b0;
      wt(HALF);
   endtask

   task automatic bitx(input logic b, output logic r);
      wt(QTR);
      sda_low <= ~b;
      wt(HALF - QTR);
      scl_low <= 1'b0;
      wt(HALF);
      r = sda;
      scl_low <= 1'b1;
   endtask

   task automatic xfer(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rxb, output logic ack_rx);
      for (int i = 7; i >= 0; i--) begin
         bitx(tx[i], rxb[i]);
      end
      bitx(ack_tx, ack_rx);
   endtask
endmodule

// File: testbench/tb_i2c_slave_wiper_por.sv
// self-checking bench for the wiper slave: write, read, refusals, supply loss.
// assumes the master model on the pins; clk_en dropped once to prove the freeze.
`timescale 1ns/1ps
module tb_i2c_slave_wiper_por;
   logic sys_clk;
   logic resetn;
   logic clk_en;
   logic scl_out;
   logic supply_ok;
   logic scl;
   logic sda;
   logic scl_oe;
   logic sda_out;
   logic sda_oe;
   logic [6:0] wiper_value;
   logic bus_active;
   logic bus_collision;
   int miscompares = 0;
   int total_checks = 0;
   integer seed = 34;
   logic [6:0] exp_q[$];
   logic [6:0] prev_wiper = 7'h3F;
   logic [6:0] cur;
   int coll_cnt = 0;
   int coll_base;
   logic ack;
   logic [7:0] rx;
   int r;

   wpt_i2c_slave dut (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .supply_ok(supply_ok),
      .scl_in(scl), .sda_in(sda), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
      .wiper_value(wiper_value), .bus_active(bus_active), .bus_collision(bus_collision));
   wpt_i2c_master_model mst (.sys_clk(sys_clk), .scl_oe_dev(scl_oe), .sda_oe_dev(sda_oe), .scl(scl), .sda(sda));

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // ----------------------------------------------------------------
   // comparison and closing
   // ----------------------------------------------------------------
   task automatic check_val(input logic [7:0] seen, input logic [7:0] exp, input string msg);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      repeat (80000) @(posedge sys_clk);
      miscompares++;
      $display("[FAIL] %0t watchdog expired", $time);
      end_of_test();
   end

   // ----------------------------------------------------------------
   // output watcher: wiper changes consume the oldest expectation
   // ----------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (resetn === 1'b1) begin
         check_val({7'h00, scl_oe}, 8'h00, "clock pulled");
         check_val({7'h00, sda_out}, 8'h00, "sda driven high");
         check_val({7'h00, scl_out}, 8'h00, "clock level driven");
         if (bus_collision === 1'b1) begin
            coll_cnt++;
         end
         if (wiper_value !== prev_wiper) begin
            if (exp_q.size() == 0) begin
               check_val({1'b0, wiper_value}, {1'b0, prev_wiper}, "unexpected wiper change");
            end else begin
               check_val({1'b0, wiper_value}, {1'b0, exp_q.pop_front()}, "wiper value");
            end
         end
      end
      prev_wiper <= wiper_value;
   end

   // ----------------------------------------------------------------
   // transaction helpers
   // ----------------------------------------------------------------
   task automatic send(input logic [7:0] b, input logic exp_nak, input string msg);
      mst.xfer(b, 1'b1, rx, ack);
      check_val({7'h00, ack}, {7'h00, exp_nak}, msg);
   endtask

   task automatic write_txn(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d, input logic exp_nak);
      mst.start();
      mst.wt(8);
      check_val({7'h00, bus_active}, {7'h00, supply_ok}, "active after start");
      send({a, 1'b0}, exp_nak, "address ack");
      if (!exp_nak) begin
         send(c, 1'b0, "command ack");
         send(d, 1'b0, "data ack");
      end
      mst.stop();
      mst.wt(8);
      check_val({7'h00, bus_active}, 8'h00, "static after stop");
   endtask

   task automatic read_txn(input logic [7:0] tx, input logic [7:0] exp);
      mst.start();
      send({wpt_pkg::WPT_SLAVE_ADDR, 1'b0}, 1'b0, "address ack");
      send(wpt_pkg::WPT_CMD_WIPER, 1'b0, "command ack");
      mst.restart();
      send({wpt_pkg::WPT_SLAVE_ADDR, 1'b1}, 1'b0, "read address ack");
      mst.xfer(tx, 1'b1, rx, ack);
      check_val(rx, exp, "read byte");
      mst.stop();
      mst.wt(8);
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      resetn = 1'b0;
      clk_en = 1'b1;
      supply_ok = 1'b1;
      repeat (16) @(posedge sys_clk);
      resetn <= 1'b1;
      mst.wt(10);
      check_val({1'b0, wiper_value}, {1'b0, wpt_pkg::WPT_WIPER_DEFAULT}, "power-up wiper");
      // msb of the data byte set to prove it is dropped
      cur = 7'h3F;
      while (cur === 7'h3F || cur === 7'h00) begin
         r = $random(seed);
         cur = r[6:0];
      end
      exp_q.push_back(cur);
      write_txn(wpt_pkg::WPT_SLAVE_ADDR, wpt_pkg::WPT_CMD_WIPER, {1'b1, cur}, 1'b0);
      read_txn(8'hFF, {1'b0, cur});
      $display("test write and read done");
      write_txn(wpt_pkg::WPT_SLAVE_ADDR ^ 7'h01, 8'h00, 8'h55, 1'b1);
      write_txn(7'h00, 8'h00, 8'h55, 1'b1);
      write_txn(wpt_pkg::WPT_SLAVE_ADDR, 8'h01, 8'h12, 1'b0);
      read_txn(8'hFF, {1'b0, cur});
      $display("test refusals done");
      // byte cut short by a stop before its acknowledge
      mst.start();
      send({wpt_pkg::WPT_SLAVE_ADDR, 1'b0}, 1'b0, "address ack");
      send(wpt_pkg::WPT_CMD_WIPER, 1'b0, "command ack");
      for (int i = 0; i < 5; i++) begin
         mst.bitx(1'b0, ack);
      end
      mst.stop();
      read_txn(8'hFF, {1'b0, cur});
      mst.start();
      send({wpt_pkg::WPT_SLAVE_ADDR, 1'b1}, 1'b1, "undefined read");
      mst.stop();
      $display("test aborts done");
      // master pulls sda low where the slave sends a one
      coll_base = coll_cnt;
      read_txn(8'h00, 8'h00);
      check_val(8'(coll_cnt - coll_base), 8'h01, "collision flagged");
      read_txn(8'hFF, {1'b0, cur});
      $display("test collision done");
      // a supply dip while frozen must not reach any flop, so no reload
      clk_en <= 1'b0;
      supply_ok <= 1'b0;
      mst.wt(10);
      supply_ok <= 1'b1;
      mst.wt(10);
      clk_en <= 1'b1;
      mst.wt(10);
      check_val({7'h00, bus_active}, 8'h00, "active while frozen");
      check_val({1'b0, wiper_value}, {1'b0, cur}, "wiper kept while frozen");
      $display("test clock enable done");
      supply_ok <= 1'b0;
      mst.wt(10);
      write_txn(wpt_pkg::WPT_SLAVE_ADDR, wpt_pkg::WPT_CMD_WIPER, 8'h11, 1'b1);
      exp_q.push_back(wpt_pkg::WPT_WIPER_DEFAULT);
      supply_ok <= 1'b1;
      mst.wt(10);
      check_val(8'(exp_q.size()), 8'h00, "reload after brown-out");
      $display("test supply done");
      end_of_test();
   end
endmodule
